// >>> hdl/lsu_pkg.sv
// Shared constants, types and encodings of the load/store unit
// Functional notes
// - Offset is a 12-bit unsigned immediate or a second register, optionally shifted.
// - Direction bit one adds the offset to the base, zero subtracts it.
// - Indexing bit set applies offset before use; clear uses plain base, offset after.
// - Pre-indexed transfers write the modified base back only with write-back set.
// - Post-indexed transfers always write the modified base back.
// - Post-indexed with write-back outside user mode drives user-space access low.
// - Register offset takes the eight shift bits; register shift amounts unsupported.
// - Size bit one moves a byte, zero moves a 32-bit word.
// - Byte load picks lane by address low bits, zero-fills upper bits.
// - Byte store replicates low byte on all four lanes; memory enables one.
// - Unaligned word load rotates addressed byte to bits 0-7; stores unchanged.
// - Single transfers never alter processor status bits.
// - Counter as base gives counter bits only, eight bytes ahead.
// - Counter as offset register gives counter plus status bits.
// - Storing the counter writes counter plus status, twelve bytes ahead.
// - Loading the counter updates only counter bits, status unchanged.
// - Used address with any of bits 26-31 set suppresses transfer, address trap.
// - Single-transfer abort leaves state unchanged; block abort keeps base write-back and earlier loads; both take data abort trap.
// - Block transfer decodes 16-bit list, bit n selects register n.
// - Ascending register order, lowest register at lowest address, counter last.
// - Without write-back base stays, unless a block load reloads it.
// - Block write-back lands end of third cycle; first store starts second cycle.
// - Only first block address checked; later addresses truncated to 26 bits.
package lsu_pkg;

   localparam int ADDR_BITS = 26;
   localparam logic [4:0] BIT_I = 5'd25;
   localparam logic [4:0] BIT_P = 5'd24;
   localparam logic [4:0] BIT_U = 5'd23;
   localparam logic [4:0] BIT_B = 5'd22;
   localparam logic [4:0] BIT_W = 5'd21;
   localparam logic [4:0] BIT_L = 5'd20;
   localparam logic [4:0] BIT_CARRY = 5'd29;
   localparam logic [1:0] CLASS_SINGLE = 2'h1;
   localparam logic [2:0] CLASS_BLOCK = 3'h4;
   localparam logic [3:0] PC_INDEX = 4'hf;
   localparam logic [31:0] PC_BASE_AHEAD = 32'h8;
   localparam logic [31:0] PC_STORE_AHEAD = 32'hc;
   localparam logic [31:0] WORD_STEP = 32'h4;
   localparam logic [31:0] COUNTER_MASK = 32'h03fffffc;
   localparam logic [31:0] STATUS_MASK = 32'hfc000003;
   localparam logic [1:0] SH_LSL = 2'h0;
   localparam logic [1:0] SH_LSR = 2'h1;
   localparam logic [1:0] SH_ASR = 2'h2;
   localparam logic [1:0] SH_ROR = 2'h3;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_CALC = 4'h1,
      S_ISSUE = 4'h2,
      S_WAIT = 4'h3,
      S_WB = 4'h4,
      S_LOAD = 4'h5,
      S_BCALC = 4'h6,
      S_BISSUE = 4'h7,
      S_BWB = 4'h8,
      S_BWAIT = 4'h9
   } lsu_state_e;

   typedef enum logic [1:0] {
      ROLE_BASE = 2'h0,
      ROLE_OFFSET = 2'h1,
      ROLE_STORE = 2'h2
   } read_role_e;

   typedef struct packed {
      logic req;
      logic write;
      logic byte_sel;
      logic user_space_access_n;
      logic [ADDR_BITS-1:0] addr;
      logic [31:0] wdata;
   } mem_req_s;

   typedef struct packed {
      logic en;
      logic [3:0] addr;
      logic [31:0] data;
   } reg_write_s;

endpackage : lsu_pkg

// >>> hdl/load_store_unit.sv
// Load/store execution unit: single-register and block transfers
`timescale 1ns/100ps
`default_nettype none
module load_store_unit
   import lsu_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic START,
   input wire logic [31:0] INSTR,
   input wire logic USER_MODE,
   input wire logic [31:0] PC_ADDR,
   input wire logic [31:0] PROCESSOR_STATUS_BITS,
   output logic BUSY,
   output logic DONE,
   output logic ADDR_EXC,
   output logic DATA_ABORT,
   output logic [3:0] RA_ADDR,
   input wire logic [31:0] RA_DATA,
   output logic [3:0] RB_ADDR,
   input wire logic [31:0] RB_DATA,
   output logic REG_WE,
   output logic [3:0] REG_WADDR,
   output logic [31:0] REG_WDATA,
   output logic PC_WE,
   output logic [31:0] PC_WDATA,
   output mem_req_s MEM,
   input wire logic MEM_ACK,
   input wire logic MEM_ABORT,
   input wire logic [31:0] MEM_RDATA
);

   // ****************************************************************
   // State
   // ****************************************************************
   lsu_state_e state, next_state;
   logic [31:0] ins, next_ins;
   logic [31:0] xfer_addr, next_xfer_addr;
   logic [31:0] wb_val, next_wb_val;
   logic [31:0] ld_data, next_ld_data;
   logic [15:0] list, next_list;
   logic [3:0] cur, next_cur;
   logic first, next_first;
   logic abort_seen, next_abort_seen;
   logic done, next_done;
   logic exc, next_exc;
   logic abt, next_abt;
   mem_req_s mem, next_mem;
   reg_write_s wr, next_wr;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Counter reads are substituted here; register file data read at index 15 is ignored
   function automatic logic [31:0] read_reg(input logic [3:0] idx, input logic [31:0] data,
                                            input read_role_e role, input logic [31:0] pc,
                                            input logic [31:0] status);
      logic [31:0] v;
      v = data;
      if (idx == PC_INDEX) begin
         case (role)
            ROLE_BASE: v = (pc + PC_BASE_AHEAD) & COUNTER_MASK;
            ROLE_OFFSET: v = ((pc + PC_BASE_AHEAD) & COUNTER_MASK)
                             | (status & STATUS_MASK);
            default: v = ((pc + PC_STORE_AHEAD) & COUNTER_MASK) | (status & STATUS_MASK);
         endcase
      end
      return v;
   endfunction : read_reg

   // Bit 0 of the control field is ignored: register shift amounts do not exist here
   function automatic logic [31:0] shift_off(input logic [31:0] val, input logic [7:0] ctl,
                                             input logic carry);
      logic [4:0] amt;
      logic [31:0] r;
      amt = ctl[7:3];
      case (ctl[2:1])
         SH_LSL: r = val << amt;
         SH_LSR: r = (amt == 5'h0) ? 32'h0 : (val >> amt);
         SH_ASR: r = (amt == 5'h0) ? {32{val[31]}} : 32'($signed(val) >>> amt);
         default: r = (amt == 5'h0) ? {carry, val[31:1]}
                                    : ((val >> amt) | (val << (6'h20 - {1'b0, amt})));
      endcase
      return r;
   endfunction : shift_off

   // ****************************************************************
   // Register-list decode
   // ****************************************************************
   logic [3:0] low_reg;
   logic [4:0] reg_count;
   always_comb begin
      low_reg = 4'h0;
      reg_count = 5'h0;
      for (int i = 15; i >= 0; i--) begin
         if (list[i]) begin
            low_reg = 4'(i);
         end
         reg_count = reg_count + {4'h0, ins[i]};
      end
   end

   // ****************************************************************
   // Decoded fields and combinational values
   // ****************************************************************
   logic f_p, f_u, f_b, f_w, f_l;
   logic [3:0] f_base, f_rd;
   logic [31:0] base, off, modified, addr, sval, span, lane;
   assign f_p = ins[BIT_P];
   assign f_u = ins[BIT_U];
   assign f_b = ins[BIT_B];
   assign f_w = ins[BIT_W];
   assign f_l = ins[BIT_L];
   assign f_base = ins[19:16];
   assign f_rd = ins[15:12];

   always_comb begin
      base = read_reg(f_base, RA_DATA, ROLE_BASE, PC_ADDR, PROCESSOR_STATUS_BITS);
      if (ins[BIT_I]) begin
         off = shift_off(read_reg(ins[3:0], RB_DATA, ROLE_OFFSET, PC_ADDR, PROCESSOR_STATUS_BITS),
                         ins[11:4], PROCESSOR_STATUS_BITS[BIT_CARRY]);
      end else begin
         off = {20'h0, ins[11:0]};
      end
      modified = f_u ? (base + off) : (base - off);
      addr = f_p ? modified : base;
      sval = read_reg(RB_ADDR, RB_DATA, ROLE_STORE, PC_ADDR, PROCESSOR_STATUS_BITS);
      span = {25'h0, reg_count, 2'h0};
      // Doubled word turns the right shift into a rotation by the low address bits
      lane = 32'({ld_data, ld_data} >> {xfer_addr[1:0], 3'h0});
      if (f_b) begin
         lane = {24'h0, lane[7:0]};
      end
   end

   assign RA_ADDR = f_base;
   assign RB_ADDR = (state == S_CALC) ? ins[3:0] : ((state == S_BISSUE) ? low_reg : f_rd);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      next_state = state;
      next_ins = ins;
      next_xfer_addr = xfer_addr;
      next_wb_val = wb_val;
      next_ld_data = ld_data;
      next_list = list;
      next_cur = cur;
      next_first = first;
      next_abort_seen = abort_seen;
      next_done = 1'b0;
      next_exc = 1'b0;
      next_abt = 1'b0;
      next_mem = mem;
      next_wr = '0;
      case (state)
         S_IDLE: begin
            if (START) begin
               next_ins = INSTR;
               next_list = INSTR[15:0];
               if (INSTR[27:26] == CLASS_SINGLE) begin
                  next_state = S_CALC;
               end else if (INSTR[27:25] == CLASS_BLOCK) begin
                  next_state = S_BCALC;
               end else begin
                  next_done = 1'b1;
               end
            end
         end
         S_CALC: begin
            next_xfer_addr = addr;
            next_wb_val = modified;
            if (|addr[31:ADDR_BITS]) begin
               next_exc = 1'b1;
               next_done = 1'b1;
               next_state = S_IDLE;
            end else begin
               next_state = S_ISSUE;
            end
         end
         S_ISSUE: begin
            next_mem.req = 1'b1;
            next_mem.write = ~f_l;
            next_mem.byte_sel = f_b;
            next_mem.user_space_access_n = ~(USER_MODE | (~f_p & f_w));
            next_mem.addr = xfer_addr[ADDR_BITS-1:0];
            next_mem.wdata = f_b ? {4{sval[7:0]}} : sval;
            next_state = S_WAIT;
         end
         S_WAIT: begin
            if (MEM_ACK) begin
               next_mem.req = 1'b0;
               next_mem.user_space_access_n = 1'b1;
               next_ld_data = MEM_RDATA;
               if (MEM_ABORT) begin
                  next_abt = 1'b1;
                  next_done = 1'b1;
                  next_state = S_IDLE;
               end else begin
                  next_state = S_WB;
               end
            end
         end
         S_WB: begin
            if (~f_p | f_w) begin
               next_wr = '{en: 1'b1, addr: f_base, data: wb_val};
            end
            if (f_l) begin
               next_state = S_LOAD;
            end else begin
               next_done = 1'b1;
               next_state = S_IDLE;
            end
         end
         S_LOAD: begin
            // Load follows write-back so a loaded base wins
            next_wr = '{en: 1'b1, addr: f_rd, data: lane};
            next_done = 1'b1;
            next_state = S_IDLE;
         end
         S_BCALC: begin
            next_first = 1'b1;
            next_abort_seen = 1'b0;
            if (f_u) begin
               next_xfer_addr = f_p ? (base + WORD_STEP) : base;
               next_wb_val = base + span;
            end else begin
               next_xfer_addr = f_p ? (base - span) : (base - span + WORD_STEP);
               next_wb_val = base - span;
            end
            if (list == 16'h0) begin
               next_done = 1'b1;
               next_state = S_IDLE;
            end else if (|next_xfer_addr[31:ADDR_BITS]) begin
               next_exc = 1'b1;
               next_done = 1'b1;
               next_state = S_IDLE;
            end else begin
               next_state = S_BISSUE;
            end
         end
         S_BISSUE: begin
            next_mem.req = 1'b1;
            next_mem.write = ~f_l;
            next_mem.byte_sel = 1'b0;
            next_mem.user_space_access_n = ~USER_MODE;
            next_mem.addr = xfer_addr[ADDR_BITS-1:0];
            next_mem.wdata = sval;
            next_cur = low_reg;
            next_list = list & ~(16'h1 << low_reg);
            next_xfer_addr = xfer_addr + WORD_STEP;
            next_first = 1'b0;
            next_state = (first & f_w & (f_base != PC_INDEX)) ? S_BWB : S_BWAIT;
         end
         S_BWB: begin
            // First store data is already captured, so the base stored first is the old one
            next_wr = '{en: 1'b1, addr: f_base, data: wb_val};
            next_state = S_BWAIT;
         end
         S_BWAIT: begin
            if (MEM_ACK) begin
               next_mem.req = 1'b0;
               next_mem.user_space_access_n = 1'b1;
               if (MEM_ABORT) begin
                  next_abort_seen = 1'b1;
               end else if (f_l & ~abort_seen) begin
                  next_wr = '{en: 1'b1, addr: cur, data: MEM_RDATA};
               end
               if (list == 16'h0) begin
                  next_abt = abort_seen | MEM_ABORT;
                  next_done = 1'b1;
                  next_state = S_IDLE;
               end else begin
                  next_state = S_BISSUE;
               end
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state <= S_IDLE;
         ins <= 32'h0;
         xfer_addr <= 32'h0;
         wb_val <= 32'h0;
         ld_data <= 32'h0;
         list <= 16'h0;
         cur <= 4'h0;
         first <= 1'b0;
         abort_seen <= 1'b0;
         done <= 1'b0;
         exc <= 1'b0;
         abt <= 1'b0;
         mem <= '{req: 1'b0, write: 1'b0, byte_sel: 1'b0, user_space_access_n: 1'b1,
                  addr: '0, wdata: 32'h0};
         wr <= '0;
      end else begin
         state <= next_state;
         ins <= next_ins;
         xfer_addr <= next_xfer_addr;
         wb_val <= next_wb_val;
         ld_data <= next_ld_data;
         list <= next_list;
         cur <= next_cur;
         first <= next_first;
         abort_seen <= next_abort_seen;
         done <= next_done;
         exc <= next_exc;
         abt <= next_abt;
         mem <= next_mem;
         wr <= next_wr;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Counter writes are masked so status bits can never change
   assign REG_WE = wr.en & (wr.addr != PC_INDEX);
   assign REG_WADDR = wr.addr;
   assign REG_WDATA = wr.data;
   assign PC_WE = wr.en & (wr.addr == PC_INDEX);
   assign PC_WDATA = wr.data & COUNTER_MASK;
   assign MEM = mem;
   assign BUSY = (state != S_IDLE);
   assign DONE = done;
   assign ADDR_EXC = exc;
   assign DATA_ABORT = abt;

endmodule : load_store_unit
`default_nettype wire

// >>> test/lsu_mem_model.sv
// Behavioural memory system with abort signalling for the load/store unit
`timescale 1ns/100ps
`default_nettype none
module lsu_mem_model
   import lsu_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire mem_req_s MEM,
   input wire logic [25:0] ABORT_ADDR,
   output logic MEM_ACK,
   output logic MEM_ABORT,
   output logic [31:0] MEM_RDATA
);
   // ***************************************
   // Sixteen words, replies alternate fast and slow
   // ***************************************
   logic [31:0] mem [16];
   logic [1:0] cnt;
   logic slow;
   logic [3:0] idx;
   logic [4:0] lane;
   assign idx = MEM.addr[5:2];
   assign lane = {MEM.addr[1:0], 3'h0};
   initial begin
      for (int k = 0; k < 16; k++) begin
         mem[k] = 32'h03020100 + k * 32'h04040404;
      end
   end
   always @(posedge CORE_CLK) begin
      MEM_ACK <= 1'b0;
      if (!RST_N) begin
         cnt <= 2'h0;
         slow <= 1'b0;
         MEM_ABORT <= 1'b0;
         MEM_RDATA <= 32'h0;
      end else if (MEM.req && !MEM_ACK) begin
         if (cnt == (slow ? 2'h2 : 2'h0)) begin
            MEM_ACK <= 1'b1;
            cnt <= 2'h0;
            slow <= !slow;
            MEM_ABORT <= (MEM.addr == ABORT_ADDR);
            MEM_RDATA <= mem[idx];
            // Manager blocks the write of an aborted access
            if (MEM.write && MEM.addr != ABORT_ADDR) begin
               if (MEM.byte_sel) begin
                  mem[idx][lane +: 8] <= MEM.wdata[lane +: 8];
               end else begin
                  mem[idx] <= MEM.wdata;
               end
            end
         end else begin
            cnt <= cnt + 2'h1;
         end
      end else begin
         // Released bus toggles each cycle between the inverse of the last word and the word itself
         MEM_RDATA <= ~MEM_RDATA;
         MEM_ABORT <= 1'b0;
      end
   end
endmodule : lsu_mem_model
`default_nettype wire

// >>> test/lsu_checker.sv
// Port-level assertions of the load/store unit
`timescale 1ns/100ps
`default_nettype none
module lsu_checker
   import lsu_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic DONE,
   input wire logic ADDR_EXC,
   input wire logic DATA_ABORT,
   input wire logic REG_WE,
   input wire logic [3:0] REG_WADDR,
   input wire logic PC_WE,
   input wire logic [31:0] PC_WDATA,
   input wire mem_req_s MEM,
   input wire logic MEM_ACK,
   input wire logic MEM_ABORT
);
   // ***************************************
   // Assertions
   // ***************************************
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   AST_EXC_WITH_DONE: assert property (ADDR_EXC |-> DONE)
      else $error("address exception without done");
   AST_EXC_NO_WRITE: assert property (ADDR_EXC |-> !REG_WE && !PC_WE && !MEM.req)
      else $error("address exception changed state");
   AST_ABORT_WITH_DONE: assert property (DATA_ABORT |-> DONE && !PC_WE)
      else $error("data abort badly reported");
   AST_ABORT_REPORTED: assert property (
      MEM.req && MEM_ACK && MEM_ABORT |-> ##[1:100] DATA_ABORT)
      else $error("abort never reported");
   AST_BYTE_LANES: assert property (
      MEM.req && MEM.write && MEM.byte_sel |-> MEM.wdata == {4{MEM.wdata[7:0]}})
      else $error("byte store not replicated");
   AST_PC_COUNTER_ONLY: assert property (PC_WE |-> (PC_WDATA & STATUS_MASK) == 32'h0)
      else $error("counter write touches status bits");
   AST_NO_PC_REGFILE: assert property (REG_WE |-> REG_WADDR != PC_INDEX)
      else $error("register file write to counter");
   AST_REQ_STANDS: assert property (
      MEM.req && !MEM_ACK |=> MEM.req && $stable(MEM.addr) && $stable(MEM.wdata))
      else $error("memory request changed before ack");
endmodule : lsu_checker
bind load_store_unit lsu_checker chk (
   .CORE_CLK(CORE_CLK),
   .RST_N(RST_N),
   .DONE(DONE),
   .ADDR_EXC(ADDR_EXC),
   .DATA_ABORT(DATA_ABORT),
   .REG_WE(REG_WE),
   .REG_WADDR(REG_WADDR),
   .PC_WE(PC_WE),
   .PC_WDATA(PC_WDATA),
   .MEM(MEM),
   .MEM_ACK(MEM_ACK),
   .MEM_ABORT(MEM_ABORT)
);
`default_nettype wire

// >>> test/load_store_unit_tb_top.sv
// Self-checking testbench of the load/store unit
`timescale 1ns/100ps
`default_nettype none
module load_store_unit_tb_top
   import lsu_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, user = 1'b0;
   logic [31:0] instr = 32'h0, pc = 32'h100, status_bits = 32'ha0000003;
   logic busy, done, aexc, dabt, we, pc_we, ack, mabt, exc, abt;
   logic [3:0] ra, rb, wa;
   logic [31:0] wd, pc_wd, rdata, ra_d, rb_d, pcw;
   logic [25:0] abort_addr = 26'h3ffffff;
   mem_req_s mreq;
   logic [31:0] rf [16];
   logic [25:0] ma [$];
   logic [31:0] md [$];
   logic mu [$];
   int failures = 0, n_checks = 0;
   assign ra_d = rf[ra];
   assign rb_d = rf[rb];
   always #5 clk = ~clk;
   load_store_unit uut (.CORE_CLK(clk), .RST_N(rst_n), .START(start), .INSTR(instr),
      .USER_MODE(user), .PC_ADDR(pc), .PROCESSOR_STATUS_BITS(status_bits), .BUSY(busy),
      .DONE(done), .ADDR_EXC(aexc), .DATA_ABORT(dabt), .RA_ADDR(ra), .RA_DATA(ra_d),
      .RB_ADDR(rb), .RB_DATA(rb_d),
      .REG_WE(we), .REG_WADDR(wa), .REG_WDATA(wd), .PC_WE(pc_we), .PC_WDATA(pc_wd),
      .MEM(mreq), .MEM_ACK(ack), .MEM_ABORT(mabt), .MEM_RDATA(rdata));
   lsu_mem_model mem (.CORE_CLK(clk), .RST_N(rst_n), .MEM(mreq), .ABORT_ADDR(abort_addr),
      .MEM_ACK(ack), .MEM_ABORT(mabt), .MEM_RDATA(rdata));
   // ***************************************
   // Monitor and tasks
   // ***************************************
   always @(posedge clk) begin
      if (mreq.req && ack) begin
         ma.push_back(mreq.addr);
         md.push_back(mreq.wdata);
         mu.push_back(mreq.user_space_access_n);
      end
      if (we) rf[wa] <= wd;
      if (pc_we) pcw <= pc_wd;
      if (done) begin
         exc <= aexc;
         abt <= dabt;
      end
   end
   function automatic logic [31:0] sdt(input logic [5:0] f, input logic [3:0] base_reg, dest,
      input logic [11:0] off);
      return {4'he, 2'b01, f, base_reg, dest, off};
   endfunction : sdt
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask : chk
   task automatic run(input logic [31:0] ins, input logic [31:0] base);
      int n;
      ma.delete();
      md.delete();
      mu.delete();
      exc = 1'b0;
      abt = 1'b0;
      rf[1] = base;
      instr = ins;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 300) failures++;
      @(posedge clk);
      #1;
   endtask : run
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #300000;
      failures++;
      wrap_up();
   end
   // ***************************************
   // Scenarios; flags are I P U B W L
   // ***************************************
   initial begin
      for (int k = 0; k < 16; k++) rf[k] = 32'h5a000000 + k;
      rf[2] = 32'h4;
      rf[3] = 32'hcafe0012;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      run(sdt(6'b011011, 1, 5, 12'h8), 32'h20);
      chk("pre add addr", 32'h28, ma[0]);
      chk("pre wb base", 32'h28, rf[1]);
      chk("word load", 32'h2b2a2928, rf[5]);
      run(sdt(6'b010001, 1, 6, 12'h4), 32'h20);
      chk("pre sub addr", 32'h1c, ma[0]);
      chk("no wb base", 32'h20, rf[1]);
      run(sdt(6'b000100, 1, 3, 12'h4), 32'h20);
      chk("post addr", 32'h20, ma[0]);
      chk("byte store data", 32'h12121212, md[0]);
      chk("post base", 32'h1c, rf[1]);
      chk("privileged pin", 32'h1, mu[0]);
      run(sdt(6'b011101, 1, 7, 12'h0), 32'h20);
      chk("byte lane 0", 32'h12, rf[7]);
      run(sdt(6'b011101, 1, 7, 12'h3), 32'h20);
      chk("byte lane 3", 32'h23, rf[7]);
      run(sdt(6'b011001, 1, 8, 12'h1), 32'h20);
      chk("rotated word", 32'h12232221, rf[8]);
      run(sdt(6'b111001, 1, 8, 12'h102), 32'h20);
      chk("shifted offset", 32'h30, ma[0]);
      chk("shifted load", 32'h33323130, rf[8]);
      run(sdt(6'b001010, 1, 3, 12'h0), 32'h30);
      chk("forced user pin", 32'h0, mu[0]);
      chk("store word", 32'hcafe0012, md[0]);
      run(sdt(6'b011000, 1, 15, 12'h0), 32'h34);
      chk("stored counter", 32'ha000010f, md[0]);
      pc = 32'h18;
      run(sdt(6'b011001, 15, 9, 12'h0), 32'h20);
      chk("counter base", 32'h20, ma[0]);
      run(sdt(6'b101001, 1, 9, 12'h00f), 32'h20);
      chk("counter offset base", 32'ha0000043, rf[1]);
      run(sdt(6'b011001, 1, 15, 12'h0), 32'h24);
      chk("counter load", 32'h03262524, pcw);
      run(sdt(6'b011001, 1, 9, 12'h0), 32'h04000000);
      chk("exception", 32'h1, exc);
      chk("suppressed", 32'h0, ma.size());
      chk("idle after trap", 32'h0, busy);
      run(sdt(6'b010001, 1, 9, 12'h4), 32'h04000000);
      chk("legal used addr", 32'h0, exc);
      chk("legal addr", 32'h3fffffc, ma[0]);
      abort_addr = 26'h28;
      run(sdt(6'b011011, 1, 10, 12'h8), 32'h20);
      chk("abort", 32'h1, abt);
      chk("abort dest", 32'h5a00000a, rf[10]);
      chk("abort base", 32'h20, rf[1]);
      abort_addr = 26'h3ffffff;
      run({4'he, 3'b100, 5'b01010, 4'h1, 16'h00a2}, 32'h20);
      chk("block count", 32'h3, ma.size());
      chk("block addr 2", 32'h28, ma[2]);
      chk("first store", 32'h20, md[0]);
      chk("block wb", 32'h2c, rf[1]);
      run({4'he, 3'b100, 5'b10001, 4'h1, 16'h1800}, 32'h38);
      chk("db addr", 32'h30, ma[0]);
      chk("low reg", 32'hcafe0012, rf[11]);
      chk("high reg", 32'ha000010f, rf[12]);
      chk("base kept", 32'h38, rf[1]);
      run({4'he, 3'b100, 5'b01000, 4'h1, 16'h0003}, 32'h04000000);
      chk("block trap", 32'h1, exc);
      chk("block suppressed", 32'h0, ma.size());
      run({4'he, 3'b100, 5'b01001, 4'h1, 16'h0c00}, 32'h03fffffc);
      chk("wrapped addr", 32'h0, ma[1]);
      chk("no late trap", 32'h0, exc);
      wrap_up();
   end
endmodule : load_store_unit_tb_top
`default_nettype wire
